// *** include/sgcp_pkg.sv ***
// Constants and types for the serial gauge command port
package sgcp_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 25;
  localparam int CLK_HZ = CLK_MHZ * 1_000_000;
  localparam int TURN_MIN_NS = 630_000;
  localparam int TURN_MIN_CYC = (TURN_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_TURN_MS = 500;
  localparam int PROG_MAX_CYC = PROG_TURN_MS * CLK_MHZ * 1000;
  localparam logic [17:0] BAUD_DIV [8] = '{
    18'(CLK_HZ / 19200), 18'(CLK_HZ / 9600), 18'(CLK_HZ / 4800),
    18'(CLK_HZ / 2400), 18'(CLK_HZ / 1200), 18'(CLK_HZ / 600),
    18'(CLK_HZ / 300), 18'(CLK_HZ / 150)};
  // ==========================================================
  // Sizes
  localparam int MSG_DEPTH = 16;
  localparam int NUM_CH = 4;
  localparam logic [3:0] CHARS_BODY = 4'hA;
  localparam logic [3:0] CHARS_TOTAL = 4'hB;
  localparam int HYST_NUM = 11;
  localparam int SCALE = 10;
  localparam int DEC_WRAP = 1000;
  // ==========================================================
  // Register map and fields
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STAT = 6'h04;
  localparam logic [5:0] OFF_SETPT = 6'h10;
  localparam int CTRL_BAUD = 0;
  localparam int CTRL_SEVEN = 3;
  localparam int CTRL_PAR = 4;
  localparam int CTRL_TWO_STOP = 6;
  localparam int CTRL_BUS_MODE = 7;
  localparam int CTRL_ADDR = 8;
  localparam logic [12:0] CTRL_RST = 13'h0000;
  localparam int STAT_MS = 0;
  localparam int STAT_TX = 3;
  localparam int STAT_PC = 4;
  localparam int STAT_NV = 8;
  localparam int SP_EXP = 8;
  localparam logic [6:0] SP_MANT_RST = 7'h0A;
  localparam logic [7:0] SP_EXP_RST = 8'h00;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // ==========================================================
  // Characters and replies
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_QUEST = 8'h3F;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [3:0] CH_BYTE_HI = 4'h4;
  localparam logic [6:0] CH_DIGIT_HI = 7'h18;
  localparam logic [79:0] RPL_PARSE = 80'h3F2053594E545820_4552;
  localparam logic [79:0] RPL_PARITY = 80'h3F2050524954_5920_4552;
  localparam logic [79:0] RPL_OVERFLOW = 80'h3F204F564552_5220_4552;
  localparam logic [79:0] RPL_STORE = 80'h3F2052414D2046_41494C;
  localparam logic [79:0] RPL_PROG_OK = 80'h2A2050524F474D_204F4B;
  // ==========================================================
  // Message sequencer states
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_RECV = 3'b001,
    MS_WAIT = 3'b010,
    MS_RTS = 3'b011,
    MS_SEND = 3'b100
  } sgcp_msg_e;
endpackage

// *** hdl/sgcp_top.sv ***
// Serial gauge command port: framing, parsing, replies, setpoints
module sgcp_top #(
  parameter int MSG_DEPTH = sgcp_pkg::MSG_DEPTH,
  parameter int NUM_CH = sgcp_pkg::NUM_CH,
  parameter int TURN_MIN_CYC = sgcp_pkg::TURN_MIN_CYC,
  parameter int PROG_MAX_CYC = sgcp_pkg::PROG_MAX_CYC,
  parameter int BAUD_SHIFT = 0 // Shortens bit periods for quick runs
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RXD,
  output logic TXD,
  output logic TX_EN,
  input wire logic RTS,
  output logic CTS,
  output logic DCD,
  output logic DSR,
  output logic RI,
  input wire logic [6:0] PRESS_MANT,
  input wire logic [7:0] PRESS_EXP,
  input wire logic [3:0] OVR_EN,
  input wire logic [3:0] OVR_VAL,
  output logic [3:0] PC_OUT,
  output logic NV_WR_REQ,
  output logic [1:0] NV_WR_CH,
  output logic [6:0] NV_WR_MANT,
  output logic [7:0] NV_WR_EXP,
  input wire logic NV_WR_ACK,
  input wire logic NV_WR_FAIL
);
  localparam int LW = $clog2(MSG_DEPTH + 1);

  typedef struct packed {
    logic rx_on;
    logic [17:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [9:0] rx_sh;
    logic rx_vld;
    logic [7:0] rx_dat;
    logic rx_perr;
    logic tx_busy;
    logic [17:0] tx_cnt;
    logic [3:0] tx_left;
    logic [11:0] tx_sh;
    logic txd;
    sgcp_pkg::sgcp_msg_e ms;
    logic [MSG_DEPTH-1:0][7:0] buff;
    logic [LW-1:0] len;
    logic perr;
    logic ovf;
    logic [79:0] reply;
    logic [3:0] nchar;
    logic [23:0] turn;
    logic prog;
    logic nv_req;
    logic [1:0] nv_ch;
    logic [3:0][6:0] sp_mant;
    logic [3:0][7:0] sp_exp;
    logic [3:0] pc_act;
    logic [3:0] pc_out;
    logic [12:0] ctrl;
    logic cts;
    logic ack;
    logic [31:0] rdata;
  } sgcp_state_s;

  localparam sgcp_state_s ST_RST = '{
    txd: 1'b1,
    tx_sh: 12'hFFF,
    ms: sgcp_pkg::MS_IDLE,
    sp_mant: {4{sgcp_pkg::SP_MANT_RST}},
    sp_exp: {4{sgcp_pkg::SP_EXP_RST}},
    ctrl: sgcp_pkg::CTRL_RST,
    default: '0};

  sgcp_state_s st_reg;
  sgcp_state_s st_next;
  logic tx_load;
  logic [7:0] tx_byte;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] to_upper(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction

  function automatic logic is_dig(input logic [7:0] c);
    return c >= 8'h30 && c <= 8'h39;
  endfunction

  // Linear ordering key of mantissa and decade
  function automatic logic signed [17:0] pkey(input logic [6:0] m,
      input logic signed [7:0] e, input logic hyst);
    logic [10:0] v;
    logic signed [17:0] ee;
    v = hyst ? 11'(m * sgcp_pkg::HYST_NUM) : 11'(m * sgcp_pkg::SCALE);
    ee = 18'(e);
    if (v >= 11'(sgcp_pkg::DEC_WRAP)) begin
      v = 11'(v / sgcp_pkg::SCALE);
      ee = ee + 18'sh1;
    end
    return 18'(ee * sgcp_pkg::DEC_WRAP + $signed({7'h00, v}));
  endfunction

  // Next reply character and its load strobe
  assign tx_load = st_reg.ms == sgcp_pkg::MS_SEND && !st_reg.tx_busy &&
                   st_reg.nchar != sgcp_pkg::CHARS_TOTAL;
  assign tx_byte = (st_reg.nchar == sgcp_pkg::CHARS_BODY) ?
                   sgcp_pkg::CH_CR : st_reg.reply[79:72];

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [3:0] nd;
    logic np;
    logic [3:0] k;
    logic [17:0] div;
    logic [9:0] w;
    logic [7:0] c;
    logic bus;
    logic [3:0] ofs;
    logic [7:0] a [8];
    logic [3:0] rem;
    logic adr_ok;
    logic [1:0] ch;
    logic [11:0] fr;
    logic p;
    logic signed [17:0] km;
    nd = st_reg.ctrl[sgcp_pkg::CTRL_SEVEN] ? 4'h7 : 4'h8;
    np = |st_reg.ctrl[sgcp_pkg::CTRL_PAR +: 2];
    k = 4'(nd + 4'(np) + 4'h1);
    div = 18'(sgcp_pkg::BAUD_DIV[st_reg.ctrl[sgcp_pkg::CTRL_BAUD +: 3]] >>
          BAUD_SHIFT);
    bus = st_reg.ctrl[sgcp_pkg::CTRL_BUS_MODE];
    w = '0;
    c = to_upper(st_reg.rx_dat);
    ofs = bus ? 4'h2 : 4'h0;
    rem = 4'h0;
    adr_ok = 1'b0;
    ch = 2'h0;
    fr = 12'hFFF;
    p = 1'b0;
    km = pkey(PRESS_MANT, PRESS_EXP, 1'b0);
    for (int i = 0; i < 8; i++) begin
      a[i] = (int'(ofs) + 2 + i < MSG_DEPTH) ?
             st_reg.buff[int'(ofs) + 2 + i] : 8'h00;
    end
    st_next = st_reg;
    st_next.rx_vld = 1'b0;
    st_next.nv_req = 1'b0;
    st_next.cts = 1'b1;

    // Receiver: start, data, parity, stop, mid-bit sampling
    if (!st_reg.rx_on) begin
      if (!RXD) begin
        st_next.rx_on = 1'b1;
        st_next.rx_cnt = div >> 1;
        st_next.rx_bit = 4'h0;
      end
    end else if (st_reg.rx_cnt != 18'h00000) begin
      st_next.rx_cnt = st_reg.rx_cnt - 18'h00001;
    end else begin
      st_next.rx_cnt = div - 18'h00001;
      if (st_reg.rx_bit == 4'h0) begin
        st_next.rx_on = !RXD;
        st_next.rx_bit = 4'h1;
      end else begin
        st_next.rx_sh = {RXD, st_reg.rx_sh[9:1]};
        st_next.rx_bit = st_reg.rx_bit + 4'h1;
        if (st_reg.rx_bit == k) begin
          st_next.rx_on = 1'b0;
          w = st_next.rx_sh >> (4'hA - k);
          st_next.rx_dat = (nd == 4'h7) ? {1'b0, w[6:0]} : w[7:0];
          st_next.rx_perr = np && ((^st_next.rx_dat ^ w[nd]) !=
              (st_reg.ctrl[sgcp_pkg::CTRL_PAR +: 2] == sgcp_pkg::PAR_ODD));
          st_next.rx_vld = 1'b1;
        end
      end
    end

    // Transmitter bit timing
    if (st_reg.tx_busy) begin
      if (st_reg.tx_cnt != 18'h00000) begin
        st_next.tx_cnt = st_reg.tx_cnt - 18'h00001;
      end else if (st_reg.tx_left == 4'h1) begin
        st_next.tx_busy = 1'b0;
        st_next.txd = 1'b1;
      end else begin
        st_next.tx_sh = {1'b1, st_reg.tx_sh[11:1]};
        st_next.txd = st_reg.tx_sh[1];
        st_next.tx_left = st_reg.tx_left - 4'h1;
        st_next.tx_cnt = div - 18'h00001;
      end
    end

    // Message assembly; bytes ignored while replying
    if (st_reg.rx_vld && (st_reg.ms == sgcp_pkg::MS_IDLE ||
        st_reg.ms == sgcp_pkg::MS_RECV)) begin
      if (c == sgcp_pkg::CH_HASH && !st_reg.rx_perr) begin
        st_next.len = '0;
        st_next.perr = 1'b0;
        st_next.ovf = 1'b0;
        st_next.ms = sgcp_pkg::MS_RECV;
      end else if (st_reg.ms == sgcp_pkg::MS_RECV) begin
        st_next.perr = st_reg.perr | st_reg.rx_perr;
        if (c == sgcp_pkg::CH_CR) begin
          // Address header, then command and modifier
          adr_ok = !bus || (st_reg.len >= LW'(2) &&
              is_hex(st_reg.buff[0]) && is_hex(st_reg.buff[1]) &&
              {hex_val(st_reg.buff[0]), hex_val(st_reg.buff[1])} ==
              {3'h0, st_reg.ctrl[sgcp_pkg::CTRL_ADDR +: 5]});
          if (st_reg.len >= LW'(ofs + 4'h2)) begin
            rem = 4'(st_reg.len - LW'(ofs + 4'h2));
          end
          ch = 2'(a[0][3:0] - 4'h1);
          st_next.turn = 24'h000000;
          st_next.ms = adr_ok ? sgcp_pkg::MS_WAIT :
                       sgcp_pkg::MS_IDLE;
          if (st_reg.ovf) begin
            st_next.reply = sgcp_pkg::RPL_OVERFLOW;
          end else if (st_next.perr) begin
            st_next.reply = sgcp_pkg::RPL_PARITY;
          end else if (st_reg.len < LW'(ofs + 4'h2) ||
              st_reg.buff[ofs] != sgcp_pkg::CH_P ||
              st_reg.buff[ofs + 4'h1] != sgcp_pkg::CH_C) begin
            st_next.reply = sgcp_pkg::RPL_PARSE;
          end else if (rem >= 4'h8 && a[0] >= sgcp_pkg::CH_ONE &&
              int'(ch) < NUM_CH && is_dig(a[1]) &&
              a[2] == sgcp_pkg::CH_DOT && is_dig(a[3]) &&
              a[4] == sgcp_pkg::CH_E && is_dig(a[6]) && is_dig(a[7]) &&
              (a[5] == sgcp_pkg::CH_PLUS || a[5] == sgcp_pkg::CH_MINUS))
          begin
            // Setpoint acts at once; storage write follows
            st_next.sp_mant[ch] = 7'(a[1][3:0] * 7'hA + a[3][3:0]);
            st_next.sp_exp[ch] = 8'(a[6][3:0] * 8'hA + a[7][3:0]);
            if (a[5] == sgcp_pkg::CH_MINUS) begin
              st_next.sp_exp[ch] = 8'h00 - st_next.sp_exp[ch];
            end
            st_next.prog = 1'b1;
            st_next.nv_req = 1'b1;
            st_next.nv_ch = ch;
            st_next.reply = sgcp_pkg::RPL_PROG_OK;
          end else if (rem == 4'h0 || a[0] == sgcp_pkg::CH_S) begin
            st_next.reply = {sgcp_pkg::CH_STAR, sgcp_pkg::CH_SP,
                {sgcp_pkg::CH_DIGIT_HI, st_reg.pc_out[0]},
                {sgcp_pkg::CH_DIGIT_HI, st_reg.pc_out[1]},
                {sgcp_pkg::CH_DIGIT_HI, st_reg.pc_out[2]},
                {sgcp_pkg::CH_DIGIT_HI, st_reg.pc_out[3]},
                {4{sgcp_pkg::CH_SP}}};
          end else if (a[0] == sgcp_pkg::CH_B) begin
            st_next.reply = {sgcp_pkg::CH_STAR, sgcp_pkg::CH_SP,
                {sgcp_pkg::CH_BYTE_HI, st_reg.pc_out},
                {7{sgcp_pkg::CH_SP}}};
          end else if (a[0] >= sgcp_pkg::CH_ONE && is_dig(a[0]) &&
              int'(a[0][3:0]) <= NUM_CH) begin
            st_next.reply = {sgcp_pkg::CH_STAR, sgcp_pkg::CH_SP,
                {sgcp_pkg::CH_DIGIT_HI, st_reg.pc_out[ch]},
                {7{sgcp_pkg::CH_SP}}};
          end else begin
            st_next.reply = sgcp_pkg::RPL_PARSE;
          end
        end else if (c != sgcp_pkg::CH_SP && c != sgcp_pkg::CH_COMMA) begin
          if (int'(st_reg.len) == MSG_DEPTH) begin
            st_next.ovf = 1'b1;
          end else begin
            st_next.buff[st_reg.len] = c;
            st_next.len = st_reg.len + LW'(1);
          end
        end
      end
    end

    // Turnaround, flow control and reply sending
    unique case (st_reg.ms)
      sgcp_pkg::MS_IDLE, sgcp_pkg::MS_RECV: begin
      end
      sgcp_pkg::MS_WAIT: begin
        st_next.turn = st_reg.turn + 24'h000001;
        st_next.nchar = 4'h0;
        if (st_reg.prog) begin
          if (NV_WR_ACK || st_reg.turn >= 24'(PROG_MAX_CYC - 1)) begin
            st_next.prog = 1'b0;
            if (NV_WR_FAIL || !NV_WR_ACK) begin
              st_next.reply = sgcp_pkg::RPL_STORE;
            end
          end
        end else if (st_reg.turn >= 24'(TURN_MIN_CYC - 1)) begin
          st_next.ms = bus ? sgcp_pkg::MS_SEND : sgcp_pkg::MS_RTS;
        end
      end
      sgcp_pkg::MS_RTS: begin
        if (RTS) begin
          st_next.ms = sgcp_pkg::MS_SEND;
        end
      end
      sgcp_pkg::MS_SEND: begin
        if (tx_load) begin
          st_next.reply = {st_reg.reply[71:0], sgcp_pkg::CH_SP};
          st_next.nchar = st_reg.nchar + 4'h1;
          p = ((nd == 4'h7) ? ^tx_byte[6:0] : ^tx_byte) ^
              (st_reg.ctrl[sgcp_pkg::CTRL_PAR +: 2] == sgcp_pkg::PAR_ODD);
          fr[0] = 1'b0;
          fr[7:1] = tx_byte[6:0];
          fr[8] = (nd == 4'h7) ? 1'b1 : tx_byte[7];
          if (np) begin
            fr[nd + 4'h1] = p;
          end
          st_next.tx_sh = fr;
          st_next.txd = 1'b0;
          st_next.tx_busy = 1'b1;
          st_next.tx_cnt = div - 18'h00001;
          // Start shown at load; every later bit, stops too, is a shift
          st_next.tx_left = 4'(k + 4'h1 +
              4'(st_reg.ctrl[sgcp_pkg::CTRL_TWO_STOP]));
        end else if (!st_reg.tx_busy) begin
          st_next.ms = sgcp_pkg::MS_IDLE;
        end
      end
      default: begin
        st_next.ms = sgcp_pkg::MS_IDLE;
      end
    endcase

    // Process control comparators with hysteresis and override
    for (int i = 0; i < 4; i++) begin
      if (i < NUM_CH) begin
        if (!st_reg.pc_act[i] &&
            km < pkey(st_reg.sp_mant[i], st_reg.sp_exp[i], 1'b0)) begin
          st_next.pc_act[i] = 1'b1;
        end else if (st_reg.pc_act[i] &&
            km > pkey(st_reg.sp_mant[i], st_reg.sp_exp[i], 1'b1)) begin
          st_next.pc_act[i] = 1'b0;
        end
        st_next.pc_out[i] = OVR_EN[i] ? OVR_VAL[i] :
                            st_next.pc_act[i];
      end else begin
        st_next.pc_act[i] = 1'b0;
        st_next.pc_out[i] = 1'b0;
      end
    end

    // Register bus slave, one wait state
    st_next.ack = (AVS_READ | AVS_WRITE) & ~st_reg.ack;
    if (AVS_READ && !st_reg.ack) begin
      st_next.rdata = 32'h00000000;
      if (AVS_ADDRESS == sgcp_pkg::OFF_CTRL) begin
        st_next.rdata[12:0] = st_reg.ctrl;
      end else if (AVS_ADDRESS == sgcp_pkg::OFF_STAT) begin
        st_next.rdata[sgcp_pkg::STAT_MS +: 3] = st_reg.ms;
        st_next.rdata[sgcp_pkg::STAT_TX] = st_reg.tx_busy;
        st_next.rdata[sgcp_pkg::STAT_PC +: 4] = st_reg.pc_out;
        st_next.rdata[sgcp_pkg::STAT_NV] = st_reg.prog;
      end else if (AVS_ADDRESS[5:4] == sgcp_pkg::OFF_SETPT[5:4]) begin
        st_next.rdata[6:0] = st_reg.sp_mant[AVS_ADDRESS[3:2]];
        st_next.rdata[sgcp_pkg::SP_EXP +: 8] =
            st_reg.sp_exp[AVS_ADDRESS[3:2]];
      end
    end
    if (AVS_WRITE && st_reg.ack) begin
      if (AVS_ADDRESS == sgcp_pkg::OFF_CTRL) begin
        if (AVS_BYTEENABLE[0]) begin
          st_next.ctrl[7:0] = AVS_WRITEDATA[7:0];
        end
        if (AVS_BYTEENABLE[1]) begin
          st_next.ctrl[12:8] = AVS_WRITEDATA[12:8];
        end
      end else if (AVS_ADDRESS[5:4] == sgcp_pkg::OFF_SETPT[5:4]) begin
        if (AVS_BYTEENABLE[0]) begin
          st_next.sp_mant[AVS_ADDRESS[3:2]] = AVS_WRITEDATA[6:0];
        end
        if (AVS_BYTEENABLE[1]) begin
          st_next.sp_exp[AVS_ADDRESS[3:2]] = AVS_WRITEDATA[15:8];
        end
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= ST_RST;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign AVS_READDATA = st_reg.rdata;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st_reg.ack;
  assign TXD = st_reg.txd;
  assign TX_EN = st_reg.ms == sgcp_pkg::MS_SEND &&
                 st_reg.ctrl[sgcp_pkg::CTRL_BUS_MODE];
  assign CTS = st_reg.cts;
  assign DCD = 1'b1;
  assign DSR = 1'b1;
  assign RI = 1'b0;
  assign PC_OUT = st_reg.pc_out;
  assign NV_WR_REQ = st_reg.nv_req;
  assign NV_WR_CH = st_reg.nv_ch;
  assign NV_WR_MANT = st_reg.sp_mant[st_reg.nv_ch];
  assign NV_WR_EXP = st_reg.sp_exp[st_reg.nv_ch];

  // ==========================================================
  // Assertions and covers
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  a_cts_held: assert property (
    $past(RESET_N) |-> CTS) else $error("clear to send dropped");
  a_modem_pins: assert property (
    DCD && DSR && !RI) else $error("modem status pins wrong");
  a_reply_start: assert property (
    tx_load && st_reg.nchar == 4'h0 |->
    tx_byte == sgcp_pkg::CH_STAR || tx_byte == sgcp_pkg::CH_QUEST)
    else $error("reply start character wrong");
  a_reply_cr: assert property (
    tx_load && st_reg.nchar == 4'hA |-> tx_byte == sgcp_pkg::CH_CR)
    else $error("reply last character not return");
  a_reply_len: assert property (
    st_reg.ms == sgcp_pkg::MS_SEND ##1 st_reg.ms != sgcp_pkg::MS_SEND
    |-> $past(st_reg.nchar) == 4'hB) else $error("reply length wrong");
  a_rts_gate: assert property (
    st_reg.ms == sgcp_pkg::MS_RTS && !RTS |=>
    st_reg.ms != sgcp_pkg::MS_SEND) else $error("reply sent without rts");
  a_turn_min: assert property (
    st_reg.ms == sgcp_pkg::MS_WAIT ##1 st_reg.ms != sgcp_pkg::MS_WAIT
    |-> $past(st_reg.turn) >= 24'(TURN_MIN_CYC - 1))
    else $error("turnaround too short");
  a_hash_clear: assert property (
    CLK_EN && st_reg.rx_vld && !st_reg.rx_perr &&
    st_reg.rx_dat == sgcp_pkg::CH_HASH &&
    (st_reg.ms == sgcp_pkg::MS_IDLE || st_reg.ms == sgcp_pkg::MS_RECV)
    |=> st_reg.len == '0 && st_reg.ms == sgcp_pkg::MS_RECV)
    else $error("hash did not clear buffer");
  a_unstarted: assert property (
    CLK_EN && st_reg.rx_vld && st_reg.ms == sgcp_pkg::MS_IDLE &&
    st_reg.rx_dat != sgcp_pkg::CH_HASH |=> st_reg.ms == sgcp_pkg::MS_IDLE)
    else $error("message accepted without start");
  a_term_first: assert property (
    st_reg.ms == sgcp_pkg::MS_WAIT && $past(st_reg.ms) != sgcp_pkg::MS_WAIT
    |-> $past(st_reg.rx_vld) && $past(st_reg.rx_dat) == sgcp_pkg::CH_CR)
    else $error("reply begun before terminator");
  a_half_duplex: assert property (
    st_reg.tx_busy |-> st_reg.ms == sgcp_pkg::MS_SEND)
    else $error("transmit outside reply phase");

  c_reply_done: cover property (
    st_reg.ms == sgcp_pkg::MS_SEND ##1 st_reg.ms == sgcp_pkg::MS_IDLE);
  c_setpoint: cover property (NV_WR_REQ ##[1:1000] !st_reg.prog);
  c_parity: cover property (
    st_reg.ms == sgcp_pkg::MS_WAIT && st_reg.reply == sgcp_pkg::RPL_PARITY);
endmodule

// *** tb/sgcp_host.sv ***
// Host terminal model on the far side of the serial link
module sgcp_host #(parameter int DIV = int'(sgcp_pkg::BAUD_DIV[0])) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic rts
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Line idles high, flow gate starts closed
  initial begin
    rxd = 1'b1;
    rts = 1'b0;
  end
  // One 8N1 character at DIV clocks per bit, LSB first, start bit at the next clock edge
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (DIV) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (DIV) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (DIV) @(posedge clk);
  endtask
  // Whole command closed by a carriage return
  task automatic send_msg(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
    end
    send_byte(sgcp_pkg::CH_CR);
  endtask
  // Mid-bit sampling of one reply character
  task automatic recv_byte(output logic [7:0] b);
    do @(negedge clk); while (txd !== 1'b0);
    repeat (DIV / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(negedge clk);
      b[i] = txd;
    end
    repeat (DIV) @(negedge clk);
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the serial gauge command port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic rxd, txd, rts, cts, dcd, dsr, ri;
  logic [3:0] ovr_en, ovr_val, pc_out;
  logic [6:0] press_mant;
  logic [7:0] press_exp;
  logic nv_req, nv_ack, nv_fail;
  logic [1:0] nv_ch;
  logic [6:0] nv_mant;
  logic [7:0] nv_exp;
  int errors, total_checks, cyc, nv_reqs;
  // ==========================================================
  // Design, host model and clock
  sgcp_top #(.TURN_MIN_CYC(20), .PROG_MAX_CYC(200), .BAUD_SHIFT(4)) uut (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(1'b1),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .RXD(rxd), .TXD(txd),
    .TX_EN(), .RTS(rts), .CTS(cts), .DCD(dcd), .DSR(dsr), .RI(ri),
    .PRESS_MANT(press_mant), .PRESS_EXP(press_exp), .OVR_EN(ovr_en),
    .OVR_VAL(ovr_val), .PC_OUT(pc_out), .NV_WR_REQ(nv_req),
    .NV_WR_CH(nv_ch), .NV_WR_MANT(nv_mant), .NV_WR_EXP(nv_exp),
    .NV_WR_ACK(nv_ack), .NV_WR_FAIL(nv_fail));
  sgcp_host #(.DIV(int'(sgcp_pkg::BAUD_DIV[0]) >> 4)) host (
    .clk(clk_sys), .txd(txd), .rxd(rxd), .rts(rts));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Compare, count and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Avalon cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Reset values, setpoint storage, unmapped place, static pins
  task automatic test_regs();
    logic [31:0] q;
    bus(1'b0, sgcp_pkg::OFF_CTRL, 32'h0, q);
    check(q, 32'h00000000, "ctrl reset");
    check(32'({dcd, dsr, ri, cts}), 32'h0000000D, "modem pins");
    bus(1'b1, 6'h14, 32'h0000FB4C, q);
    bus(1'b0, 6'h14, 32'h0, q);
    check(q, 32'h0000FB4C, "setpoint");
    bus(1'b0, 6'h3C, 32'h0, q);
    check(q, 32'h00000000, "unmapped");
  endtask
  // Status query after a false start, held reply, then full reply
  task automatic test_status();
    logic [7:0] b;
    int quiet;
    string want;
    want = "* 1000    ";
    quiet = 0;
    host.send_msg("#q#pcs");
    repeat (3000) begin
      @(negedge clk_sys);
      quiet += int'(txd !== 1'b1);
    end
    check(quiet, 0, "reply held");
    @(posedge clk_sys);
    host.rts <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      host.recv_byte(b);
      check(b, want[i], "reply char");
    end
    host.recv_byte(b);
    check(b, sgcp_pkg::CH_CR, "reply end");
    check(pc_out, 4'h1, "override");
  endtask
  // Unstarted message dropped, then a setpoint command; failed store reported
  task automatic test_prog();
    logic [7:0] b;
    logic [31:0] q;
    int quiet;
    quiet = 0;
    host.send_msg("pcs");
    repeat (500) begin
      @(negedge clk_sys);
      quiet += int'(txd !== 1'b1);
    end
    check(quiet, 0, "no start");
    host.send_msg("#pc21.5E-03");
    check(nv_reqs, 1, "store request");
    check({nv_ch, nv_mant, nv_exp}, 17'h08FFD, "store word");
    @(posedge clk_sys);
    nv_ack <= 1'b1;
    nv_fail <= 1'b1;
    @(posedge clk_sys);
    nv_ack <= 1'b0;
    nv_fail <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      host.recv_byte(b);
      check(b, sgcp_pkg::RPL_STORE[79 - 8 * i -: 8], "store reply");
    end
    host.recv_byte(b);
    check(b, sgcp_pkg::CH_CR, "store end");
    bus(1'b0, 6'h14, 32'h0, q);
    check(q, 32'h0000FD0F, "setpoint kept");
  endtask
  // Main sequence and hang guard
  initial begin
    reset_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {ovr_en, ovr_val, press_mant, press_exp} = {8'h11, 7'h32, 8'h00};
    {nv_ack, nv_fail} = 2'b00;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_regs();
    test_status();
    test_prog();
    summarize();
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    nv_reqs <= nv_reqs + int'(nv_req);
    if (cyc == 80000) begin
      errors++;
      summarize();
    end
  end
endmodule
